// file: hw/analog_command_conditioner.v
// Three channel analog command conditioner with classic Wishbone registers
`timescale 1ns/10ps
`include "analog_command_conditioner_regs.vh"

// Contract
// - Three independent channels, each with own filter, drift, offset, zone, gain.
// - Each channel low-pass filters samples with programmable time constant.
// - Time constant zero passes the raw sample unchanged.
// - Drift, offset and dead zone are separate stages after the filter.
// - Stored zero drift is subtracted from the filtered sample.
// - Programmed offset is subtracted, giving zero when input equals offset.
// - Result forced to zero within plus or minus dead-zone width.
// - Outside the zone, input minus offset, unreduced, scaled by gain/10000.
// - Command percent is processed sample over 10000 mV times gain.
// - Speed mode gives rated speed times command percent in rpm.
// - Torque mode gives the command percent unscaled.
// - Sampled voltage and command of each channel visible continuously.
// - Zero when magnitude of offset-corrected sample is below zone width.
// - Calibration code 1 to 3 captures drift of that channel, 4 all.
module analog_command_conditioner #(
   parameter SAMPLE_PERIOD_US = 100
) (
   // Clock and reset
   input wire mclk_in,
   input wire rst_in,
   // Wishbone slave
   input wire wb_cyc_in,
   input wire wb_stb_in,
   input wire wb_we_in,
   input wire [7:0] wb_adr_in,
   input wire [3:0] wb_sel_in,
   input wire [31:0] wb_dat_in,
   output reg [31:0] wb_dat_out,
   output wire wb_ack_out,
   // Sample stream
   input wire sample_valid_in,
   input wire [15:0] ch1_sample_in,
   input wire [15:0] ch2_sample_in,
   input wire [15:0] ch3_sample_in,
   // Monitor and command
   output wire [15:0] ch1_sampled_voltage_out,
   output wire [15:0] ch2_sampled_voltage_out,
   output wire [15:0] ch3_sampled_voltage_out,
   output wire [15:0] ch1_cmd_out,
   output wire [15:0] ch2_cmd_out,
   output wire [15:0] ch3_cmd_out,
   output reg cmd_valid_out
);

////////////////////////////////////////////////////////////////////////////
// Functions

// Byte-lane merge for 16-bit registers; upper lanes are not stored
function [15:0] merge16;
   input [15:0] old;
   input [31:0] dat;
   input [3:0] sel;
   begin
      merge16[7:0] = sel[0] ? dat[7:0] : old[7:0];
      merge16[15:8] = sel[1] ? dat[15:8] : old[15:8];
   end
endfunction

// Filter shift: smallest n with 2^n >= tc/Ts + 1, 1..15. A power of two
// stands in for a divider; the corner sits within a factor two.
function [3:0] filt_shift;
   input [15:0] tc_ms;
   integer ratio;
   integer n;
   begin
      ratio = (tc_ms * 1000) / SAMPLE_PERIOD_US + 1;
      // Long constants beyond the table clamp to the slowest filter
      filt_shift = 4'hF;
      for (n = 15; n >= 1; n = n - 1) begin
         if ((1 << n) >= ratio)
            filt_shift = n[3:0];
      end
   end
endfunction

// Saturate a wide value into the signed 16-bit command range
function [15:0] sat16;
   input signed [33:0] v;
   begin
      if (v > 34'sd32767)
         sat16 = `CMD_MAX;
      else if (v < -34'sd32767)
         sat16 = `CMD_MIN;
      else
         sat16 = v[15:0];
   end
endfunction

////////////////////////////////////////////////////////////////////////////
// Storage

reg signed [15:0] offset_setting_q [0:2];
reg [15:0] dead_zone_width_q [0:2];
reg [15:0] gain_percent_q [0:2];
reg [15:0] filter_time_constant_q [0:2];
reg signed [15:0] zero_drift_value_q [0:2];
reg signed [15:0] sampled_voltage_q [0:2];
reg signed [31:0] filt_acc_q [0:2];
reg [15:0] cmd_q [0:2];
reg mode_q;
reg [15:0] rated_speed_q;
reg ack_q;
reg busy_q;
reg [1:0] idx_q;
integer i;
integer j;

////////////////////////////////////////////////////////////////////////////
// Bus decode

wire req = wb_cyc_in & wb_stb_in & ~ack_q;
wire [1:0] adr_ch = wb_adr_in[6:5];
wire [7:0] adr_ofs = {3'h0, wb_adr_in[4:0]};
wire in_ch = (wb_adr_in[7] == 1'b0) && (adr_ch != 2'h3);
wire wr = req & wb_we_in;

assign wb_ack_out = ack_q;

////////////////////////////////////////////////////////////////////////////
// Processing datapath for the channel at idx_q

reg signed [31:0] acc_d;
reg signed [31:0] x_ext;
reg signed [32:0] filt_diff;
reg signed [32:0] filt_step;
reg signed [17:0] filt_mv;
reg signed [17:0] b1;
reg signed [17:0] b1_abs;
reg signed [17:0] b2;
reg signed [33:0] pct_wide;
reg signed [15:0] pct;
reg signed [33:0] speed_wide;
reg [15:0] cmd_d;

always @* begin
   x_ext = {sampled_voltage_q[idx_q], 16'h0000};
   // One bit of headroom, a full-scale swing would wrap in 32 bits
   filt_diff = {x_ext[31], x_ext} -
      {filt_acc_q[idx_q][31], filt_acc_q[idx_q]};
   filt_step = filt_diff >>> filt_shift(filter_time_constant_q[idx_q]);
   if (filter_time_constant_q[idx_q] == 16'h0000) begin
      acc_d = x_ext;
   end else begin
      acc_d = filt_acc_q[idx_q] + filt_step[31:0];
   end
   filt_mv = {{2{acc_d[31]}}, acc_d[31:`FILT_FRAC]};
   // Drift then offset, after the filter
   b1 = filt_mv - {{2{zero_drift_value_q[idx_q][15]}},
      zero_drift_value_q[idx_q]};
   b1 = b1 - {{2{offset_setting_q[idx_q][15]}},
      offset_setting_q[idx_q]};
   b1_abs = b1[17] ? -b1 : b1;
   if (b1_abs < $signed({2'b00, dead_zone_width_q[idx_q]}))
      b2 = 18'sh00000;
   else
      b2 = b1;
   // Percent in tenths: b2 mV / 10000 * gain in tenths
   pct_wide = ($signed({{16{b2[17]}}, b2}) *
      $signed({18'h00000, gain_percent_q[idx_q]})) /
      `FULL_SCALE_MV;
   pct = sat16(pct_wide);
   speed_wide = ($signed({{18{pct[15]}}, pct}) *
      $signed({18'h00000, rated_speed_q})) / `PCT_FULL;
   if (mode_q == `MODE_TORQUE)
      cmd_d = pct;
   else
      cmd_d = sat16(speed_wide);
end

////////////////////////////////////////////////////////////////////////////
// Sequencer: one channel per cycle, three cycles per sample set

always @(posedge mclk_in) begin
   if (rst_in) begin
      busy_q <= 1'b0;
      idx_q <= 2'h0;
      cmd_valid_out <= 1'b0;
      for (i = 0; i < 3; i = i + 1) begin
         sampled_voltage_q[i] <= 16'h0000;
         filt_acc_q[i] <= 32'h00000000;
         cmd_q[i] <= 16'h0000;
      end
   end else begin
      cmd_valid_out <= 1'b0;
      if (busy_q) begin
         // Settings are read live, so a change acts on this pass
         filt_acc_q[idx_q] <= acc_d;
         cmd_q[idx_q] <= cmd_d;
         if (idx_q == 2'h2) begin
            busy_q <= 1'b0;
            idx_q <= 2'h0;
            cmd_valid_out <= 1'b1;
         end else begin
            idx_q <= idx_q + 2'h1;
         end
      end
      // A new set restarts the pass; it must not come while busy
      if (sample_valid_in) begin
         sampled_voltage_q[0] <= ch1_sample_in;
         sampled_voltage_q[1] <= ch2_sample_in;
         sampled_voltage_q[2] <= ch3_sample_in;
         busy_q <= 1'b1;
         idx_q <= 2'h0;
      end
   end
end

////////////////////////////////////////////////////////////////////////////
// Register writes, calibration and read data

always @(posedge mclk_in) begin
   if (rst_in) begin
      ack_q <= 1'b0;
      wb_dat_out <= 32'h00000000;
      mode_q <= `MODE_SPEED;
      rated_speed_q <= `RST_RATED_SPEED;
      for (j = 0; j < 3; j = j + 1) begin
         offset_setting_q[j] <= 16'h0000;
         dead_zone_width_q[j] <= 16'h0000;
         gain_percent_q[j] <= `RST_GAIN;
         filter_time_constant_q[j] <= `RST_FILTER_TC;
         zero_drift_value_q[j] <= 16'h0000;
      end
   end else begin
      ack_q <= req;
      if (req) begin
         wb_dat_out <= 32'h00000000;
         if (in_ch) begin
            case (adr_ofs)
               `OFS_OFFSET: begin
                  wb_dat_out <= {{16{offset_setting_q[adr_ch][15]}},
                     offset_setting_q[adr_ch]};
               end
               `OFS_DEAD_ZONE: begin
                  wb_dat_out <= {16'h0000, dead_zone_width_q[adr_ch]};
               end
               `OFS_GAIN: begin
                  wb_dat_out <= {16'h0000, gain_percent_q[adr_ch]};
               end
               `OFS_FILTER_TC: begin
                  wb_dat_out <= {16'h0000, filter_time_constant_q[adr_ch]};
               end
               `OFS_ZERO_DRIFT: begin
                  wb_dat_out <= {{16{zero_drift_value_q[adr_ch][15]}},
                     zero_drift_value_q[adr_ch]};
               end
               `OFS_SAMPLED: begin
                  wb_dat_out <= {{16{sampled_voltage_q[adr_ch][15]}},
                     sampled_voltage_q[adr_ch]};
               end
               `OFS_COMMAND: begin
                  wb_dat_out <= {{16{cmd_q[adr_ch][15]}}, cmd_q[adr_ch]};
               end
               default: begin
                  wb_dat_out <= 32'h00000000;
               end
            endcase
         end else begin
            case (wb_adr_in)
               `ADR_MODE: wb_dat_out <= {31'h00000000, mode_q};
               `ADR_RATED_SPEED: wb_dat_out <= {16'h0000, rated_speed_q};
               default: wb_dat_out <= 32'h00000000;
            endcase
         end
      end
      if (wr && in_ch) begin
         case (adr_ofs)
            `OFS_OFFSET: offset_setting_q[adr_ch] <=
               merge16(offset_setting_q[adr_ch], wb_dat_in, wb_sel_in);
            `OFS_DEAD_ZONE: dead_zone_width_q[adr_ch] <=
               merge16(dead_zone_width_q[adr_ch], wb_dat_in, wb_sel_in);
            `OFS_GAIN: gain_percent_q[adr_ch] <=
               merge16(gain_percent_q[adr_ch], wb_dat_in, wb_sel_in);
            `OFS_FILTER_TC: filter_time_constant_q[adr_ch] <=
               merge16(filter_time_constant_q[adr_ch], wb_dat_in,
               wb_sel_in);
            `OFS_ZERO_DRIFT: zero_drift_value_q[adr_ch] <=
               merge16(zero_drift_value_q[adr_ch], wb_dat_in, wb_sel_in);
            default: begin
            end
         endcase
      end
      if (wr && !in_ch) begin
         case (wb_adr_in)
            `ADR_MODE: begin
               if (wb_sel_in[0])
                  mode_q <= wb_dat_in[0];
            end
            `ADR_RATED_SPEED: begin
               rated_speed_q <= merge16(rated_speed_q, wb_dat_in,
                  wb_sel_in);
            end
            `ADR_CALIB: begin
               // Capture the latest raw sample as the channel's drift
               if (wb_sel_in[0]) begin
                  for (j = 0; j < 3; j = j + 1) begin
                     if (wb_dat_in[2:0] == `CAL_ALL ||
                         wb_dat_in[2:0] == j[2:0] + `CAL_CH1)
                        zero_drift_value_q[j] <=
                           sampled_voltage_q[j];
                  end
               end
            end
            default: begin
            end
         endcase
      end
   end
end

////////////////////////////////////////////////////////////////////////////
// Outputs

assign ch1_sampled_voltage_out = sampled_voltage_q[0];
assign ch2_sampled_voltage_out = sampled_voltage_q[1];
assign ch3_sampled_voltage_out = sampled_voltage_q[2];
assign ch1_cmd_out = cmd_q[0];
assign ch2_cmd_out = cmd_q[1];
assign ch3_cmd_out = cmd_q[2];

endmodule // analog_command_conditioner

// file: hw/analog_command_conditioner_regs.vh
// Register offsets, field values and reset values of the command conditioner
`ifndef ANALOG_COMMAND_CONDITIONER_REGS_VH
`define ANALOG_COMMAND_CONDITIONER_REGS_VH

// Per channel block: byte base of channel n is n * CH_STRIDE
`define CH_STRIDE 8'h20
`define OFS_OFFSET 8'h00
`define OFS_DEAD_ZONE 8'h04
`define OFS_GAIN 8'h08
`define OFS_FILTER_TC 8'h0C
`define OFS_ZERO_DRIFT 8'h10
`define OFS_SAMPLED 8'h14
`define OFS_COMMAND 8'h18

// Global registers
`define ADR_MODE 8'h60
`define ADR_RATED_SPEED 8'h64
`define ADR_CALIB 8'h68

// Calibration codes
`define CAL_NONE 3'h0
`define CAL_CH1 3'h1
`define CAL_CH3 3'h3
`define CAL_ALL 3'h4

// Modes
`define MODE_SPEED 1'b0
`define MODE_TORQUE 1'b1

// Reset values
`define RST_GAIN 16'h03E8
`define RST_FILTER_TC 16'h0002
`define RST_RATED_SPEED 16'h0BB8

// Scaling: full scale in mV, 100 percent in tenths
`define FULL_SCALE_MV 34'sd10000
`define PCT_FULL 34'sd1000
`define CMD_MAX 16'sh7FFF
`define CMD_MIN 16'sh8001

// Filter accumulator fraction bits
`define FILT_FRAC 16
`endif

// file: verif/conditioner_checker_asserts.sv
// Assertion checker for the analog command conditioner
`timescale 1ns/10ps
module conditioner_checker (
   // Clock and reset
   input wire mclk_in,
   input wire rst_in,
   // Bus
   input wire wb_cyc_in,
   input wire wb_stb_in,
   input wire wb_we_in,
   input wire [7:0] wb_adr_in,
   input wire [31:0] wb_dat_out,
   input wire wb_ack_out,
   // Samples and commands
   input wire sample_valid_in,
   input wire [15:0] ch1_sample_in,
   input wire [15:0] ch1_sampled_voltage_out,
   input wire [15:0] ch1_cmd_out,
   input wire [15:0] ch3_cmd_out,
   input wire cmd_valid_out
);
   default clocking @(posedge mclk_in); endclocking
   default disable iff (rst_in);
   wire req = wb_cyc_in && wb_stb_in && !wb_ack_out;
   ////////////////////////////////////////
   property p_ack; req |=> wb_ack_out; endproperty
   a_ack: assert property (p_ack) else $error("no ack");
   property p_ack_pulse; wb_ack_out |=> !wb_ack_out; endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("long ack");
   // Space above the map reads as zero
   property p_unmapped;
      req && !wb_we_in && wb_adr_in >= 8'h6C |=> wb_dat_out == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped data");
   property p_latch;
      sample_valid_in |=> ch1_sampled_voltage_out == $past(ch1_sample_in);
   endproperty
   a_latch: assert property (p_latch) else $error("sample not shown");
   property p_pass;
      sample_valid_in ##1 !sample_valid_in [*3] |=> cmd_valid_out;
   endproperty
   a_pass: assert property (p_pass) else $error("pass not done");
   property p_cause; cmd_valid_out |-> $past(sample_valid_in, 4); endproperty
   a_cause: assert property (p_cause) else $error("stray valid");
   // Commands only move during a pass, never in between
   property p_hold1; !$past(sample_valid_in, 2) |-> $stable(ch1_cmd_out); endproperty
   a_hold1: assert property (p_hold1) else $error("ch1 moved");
   property p_hold3; !$past(sample_valid_in, 4) |-> $stable(ch3_cmd_out); endproperty
   a_hold3: assert property (p_hold3) else $error("ch3 moved");
   c_pass: cover property (cmd_valid_out);
   c_write: cover property (req && wb_we_in);
   c_sat: cover property (cmd_valid_out && ch1_cmd_out == 16'h7FFF);
endmodule // conditioner_checker

bind analog_command_conditioner conditioner_checker u_chk (
   .mclk_in(mclk_in), .rst_in(rst_in), .wb_cyc_in(wb_cyc_in),
   .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
   .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
   .sample_valid_in(sample_valid_in), .ch1_sample_in(ch1_sample_in),
   .ch1_sampled_voltage_out(ch1_sampled_voltage_out),
   .ch1_cmd_out(ch1_cmd_out), .ch3_cmd_out(ch3_cmd_out),
   .cmd_valid_out(cmd_valid_out));

// file: verif/mv_sampler.sv
// Behavioural model of the three channel millivolt sampler
`timescale 1ns/10ps
module mv_sampler (
   // Clock
   input wire mclk_in,
   // Sample stream
   output reg valid_out,
   output reg [15:0] s1_out,
   output reg [15:0] s2_out,
   output reg [15:0] s3_out
);
   initial begin
      valid_out = 1'b0;
      s1_out = 16'h0000;
      s2_out = 16'h0000;
      s3_out = 16'h0000;
   end
   // One pulse carries all three channels
   task send(input [15:0] a, b, c);
      begin
         @(posedge mclk_in);
         valid_out <= 1'b1;
         s1_out <= a;
         s2_out <= b;
         s3_out <= c;
         @(posedge mclk_in);
         // Stale lines show the inverse so a late latch is caught
         valid_out <= 1'b0;
         s1_out <= ~a;
         s2_out <= ~b;
         s3_out <= ~c;
      end
   endtask
endmodule // mv_sampler

// file: verif/testbench.sv
// Self-checking bench for the analog command conditioner
`timescale 1ns/10ps
module testbench;
   reg mclk_in;
   reg rst_in;
   reg cyc;
   reg we;
   reg [7:0] adr;
   reg [15:0] wd;
   reg [15:0] q;
   wire [31:0] rd;
   wire ack;
   wire sv;
   wire cv;
   wire [15:0] s1, s2, s3, v1, v2, v3, c1, c2, c3;
   integer n_mismatch;
   integer compares;
   integer i;
   analog_command_conditioner dut (.mclk_in(mclk_in), .rst_in(rst_in),
      .wb_cyc_in(cyc), .wb_stb_in(cyc), .wb_we_in(we), .wb_adr_in(adr),
      .wb_sel_in(4'hF), .wb_dat_in({16'h0000, wd}), .wb_dat_out(rd),
      .wb_ack_out(ack), .sample_valid_in(sv), .ch1_sample_in(s1),
      .ch2_sample_in(s2), .ch3_sample_in(s3),
      .ch1_sampled_voltage_out(v1), .ch2_sampled_voltage_out(v2),
      .ch3_sampled_voltage_out(v3), .ch1_cmd_out(c1), .ch2_cmd_out(c2),
      .ch3_cmd_out(c3), .cmd_valid_out(cv));
   mv_sampler smp (.mclk_in(mclk_in), .valid_out(sv), .s1_out(s1),
      .s2_out(s2), .s3_out(s3));
   ////////////////////////////////////////
   task chk(input [15:0] got, input [15:0] exp);
      begin
         compares = compares + 1;
         if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task bus(input w, input [7:0] a, input [15:0] d);
      begin
         @(posedge mclk_in);
         cyc <= 1'b1;
         we <= w;
         adr <= a;
         wd <= d;
         @(posedge mclk_in);
         while (ack !== 1'b1) @(posedge mclk_in);
         q = rd[15:0];
         cyc <= 1'b0;
      end
   endtask
   task rdc(input [7:0] a, input [15:0] e);
      begin
         bus(1'b0, a, 16'h0000);
         chk(q, e);
      end
   endtask
   task pass(input [15:0] a, b, c, x, y, z);
      begin
         smp.send(a, b, c);
         while (cv !== 1'b1) @(posedge mclk_in);
         chk(v1, a);
         chk(v2, b);
         chk(v3, c);
         chk(c1, x);
         chk(c2, y);
         chk(c3, z);
      end
   endtask
   task report_and_stop;
      begin
         $display("mismatches %0d comparisons %0d", n_mismatch, compares);
         if (n_mismatch == 0 && compares > 0) begin
            $display("Result: passed");
         end else begin
            $display("Result: failed");
         end
         $finish;
      end
   endtask
   ////////////////////////////////////////
   initial begin
      mclk_in = 1'b0;
      forever #25 mclk_in = ~mclk_in;
   end
   initial begin
      repeat (20000) @(posedge mclk_in);
      n_mismatch = n_mismatch + 1;
      report_and_stop;
   end
   initial begin
      rst_in = 1'b1;
      cyc = 1'b0;
      we = 1'b0;
      adr = 8'h00;
      wd = 16'h0000;
      n_mismatch = 0;
      compares = 0;
      repeat (6) @(posedge mclk_in);
      rst_in <= 1'b0;
      rdc(8'h08, 16'h03E8);
      rdc(8'h2C, 16'h0002);
      rdc(8'h64, 16'h0BB8);
      rdc(8'h7C, 16'h0000);
      for (i = 0; i < 3; i = i + 1) begin
         bus(1'b1, {1'b0, i[1:0], 5'h0C}, 16'h0000);
      end
      bus(1'b1, 8'h20, 16'h0FA0);
      bus(1'b1, 8'h24, 16'h0320);
      bus(1'b1, 8'h40, 16'h0FA0);
      bus(1'b1, 8'h44, 16'h0320);
      pass(16'h1388, 16'h1194, 16'h12C0, 16'h05DC, 16'h0, 16'h00F0);
      pass(16'hEC78, 16'h0C7F, 16'h0, 16'hFA24, 16'hFF10, 16'hFB50);
      bus(1'b1, 8'h60, 16'h0001);
      pass(16'hEC78, 16'h0C7F, 16'h0, 16'hFE0C, 16'hFFB0, 16'hFE70);
      bus(1'b1, 8'h60, 16'h0000);
      bus(1'b1, 8'h64, 16'h2710);
      bus(1'b1, 8'h08, 16'h2710);
      pass(16'h2710, 16'h0FA0, 16'h36B0, 16'h7FFF, 16'h0, 16'h2710);
      bus(1'b1, 8'h68, 16'h0001);
      rdc(8'h10, 16'h2710);
      rdc(8'h30, 16'h0000);
      bus(1'b1, 8'h68, 16'h0002);
      rdc(8'h30, 16'h0FA0);
      bus(1'b1, 8'h68, 16'h0003);
      rdc(8'h50, 16'h36B0);
      rdc(8'h68, 16'h0000);
      pass(16'h1388, 16'h1388, 16'h1388, 16'h8001, 16'hF448, 16'hCD38);
      bus(1'b1, 8'h68, 16'h0004);
      for (i = 0; i < 3; i = i + 1) begin
         rdc({1'b0, i[1:0], 5'h10}, 16'h1388);
      end
      // A code outside 1 to 4 must leave every drift alone
      bus(1'b1, 8'h68, 16'h0005);
      rdc(8'h10, 16'h1388);
      pass(16'h1388, 16'h1388, 16'h1388, 16'h0, 16'hF060, 16'hF060);
      // A one step move is cut to a sixteenth by the shortest filter
      bus(1'b1, 8'h0C, 16'h0001);
      pass(16'h19C8, 16'h1388, 16'h1388, 16'h03E8, 16'hF060, 16'hF060);
      report_and_stop;
   end
endmodule // testbench
